// [verilog/mdio_switch_register_access.sv]
// Overview of operation
// - Opcode 10 with PHY address bits 2:1 set reads
// - Opcode 01 with PHY address bits 2:1 set writes
// - Address is phy[4:3], phy[0], reg[4:0]
// - Controller floats first turnaround bit, device drives zero
// - Registers are eight bits, low data byte
// - Reads return zero upper byte, then register
// - Writes ignore upper byte, store low byte
// - Ordinary framing: 32 ones, start, fields, data
// - Power-down control decoded at 0x0E-0x0F
// - Port control/status at 0x28-0x2F and 0x38-0x3F
// - Self-test control register at 0x88
`timescale 1ns/10ps
`default_nettype none
`include "mdio_regs_cfg.svh"
module mdio_switch_register_access
  import mdio_regs_pkg::*;
#(
  parameter logic [7:0] FAMILY_IDENTIFIER = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Management pins
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio_out,
  output logic o_mdio_oe,
  // Decoded control registers
  output logic [15:0] o_power_down_ctrl,
  output logic [63:0] o_port1_ctrl,
  output logic [63:0] o_port2_ctrl,
  output logic [7:0] o_self_test_ctrl
);

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [7:0] form_addr(input logic [4:0] phy, input logic [4:0] rad);
    form_addr = {phy[4:3], phy[0], rad};
  endfunction

  logic [1:0] synced;
  logic mdc_s;
  logic mdio_s;
  logic mdc_prev;
  logic mdc_rise;
  mgmt_state_t state;
  logic [5:0] ones_cnt;
  logic [4:0] bit_cnt;
  logic [11:0] hdr;
  logic [11:0] next_hdr;
  logic is_read;
  logic is_write;
  logic [7:0] addr;
  logic [15:0] rd_shift;
  logic [15:0] wr_shift;
  logic wr_commit;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  reg_byte_t regs [0:`CFG_REG_COUNT-1];
  logic hdr_end;
  logic ext_sel;
  logic dec_read;
  logic dec_write;

  mdio_input_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async({i_mdc, i_mdio}),
    .o_sync(synced)
  );

  assign mdc_s = synced[1];
  assign mdio_s = synced[0];
  assign mdc_rise = mdc_s & ~mdc_prev;
  assign next_hdr = {hdr[10:0], mdio_s};
  assign hdr_end = mdc_rise && (state == ST_HEADER) && (bit_cnt == `CFG_HDR_BITS - 5'h01);
  assign ext_sel = (next_hdr[7:6] == `CFG_EXT_SEL);
  assign dec_read = ext_sel && (next_hdr[11:10] == `CFG_OP_READ);
  assign dec_write = ext_sel && (next_hdr[11:10] == `CFG_OP_WRITE);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= mdc_s;
    end
  end

  // Frame sequencing, one step per management clock rising edge
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_PREAMBLE;
      ones_cnt <= 6'h00;
      bit_cnt <= 5'h00;
      hdr <= 12'h000;
      is_read <= 1'b0;
      is_write <= 1'b0;
      addr <= 8'h00;
    end else if (mdc_rise) begin
      unique case (state)
        ST_PREAMBLE: begin
          if (mdio_s) begin
            if (ones_cnt != `CFG_PREAMBLE_ONES) begin
              ones_cnt <= ones_cnt + 6'h01;
            end
          end else if (ones_cnt == `CFG_PREAMBLE_ONES) begin
            state <= ST_START;
            ones_cnt <= 6'h00;
          end else begin
            ones_cnt <= 6'h00;
          end
        end
        ST_START: begin
          bit_cnt <= 5'h00;
          state <= mdio_s ? ST_HEADER : ST_PREAMBLE;
        end
        ST_HEADER: begin
          hdr <= next_hdr;
          bit_cnt <= bit_cnt + 5'h01;
          if (hdr_end) begin
            bit_cnt <= 5'h00;
            is_read <= dec_read;
            is_write <= dec_write;
            addr <= form_addr(next_hdr[9:5], next_hdr[4:0]);
            state <= (dec_read || dec_write) ? ST_TURN : ST_PREAMBLE;
          end
        end
        ST_TURN: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == 5'h01) begin
            bit_cnt <= 5'h00;
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `CFG_DATA_BITS - 5'h01) begin
            bit_cnt <= 5'h00;
            is_read <= 1'b0;
            is_write <= 1'b0;
            state <= ST_PREAMBLE;
          end
        end
      endcase
    end
  end

  // Read data path and line driver
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_shift <= 16'h0000;
      o_mdio_out <= 1'b0;
      o_mdio_oe <= 1'b0;
    end else if (mdc_rise) begin
      if (hdr_end && dec_read) begin
        if (form_addr(next_hdr[9:5], next_hdr[4:0]) == `CFG_ADDR_FAMILY) begin
          rd_shift <= {`CFG_READ_PAD, FAMILY_IDENTIFIER};
        end else begin
          rd_shift <= {`CFG_READ_PAD, regs[form_addr(next_hdr[9:5], next_hdr[4:0])]};
        end
      end else if (state == ST_TURN && is_read) begin
        if (bit_cnt == 5'h00) begin
          o_mdio_oe <= 1'b1;
          o_mdio_out <= 1'b0;
        end else begin
          o_mdio_out <= rd_shift[15];
          rd_shift <= {rd_shift[14:0], 1'b0};
        end
      end else if (state == ST_DATA && is_read) begin
        if (bit_cnt == `CFG_DATA_BITS - 5'h01) begin
          o_mdio_oe <= 1'b0;
          o_mdio_out <= 1'b0;
        end else begin
          o_mdio_out <= rd_shift[15];
          rd_shift <= {rd_shift[14:0], 1'b0};
        end
      end
    end
  end

  // Write data capture; turnaround bits on writes are the controller's
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_shift <= 16'h0000;
      wr_commit <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_commit <= 1'b0;
      if (mdc_rise && state == ST_DATA && is_write) begin
        wr_shift <= {wr_shift[14:0], mdio_s};
        if (bit_cnt == `CFG_DATA_BITS - 5'h01) begin
          wr_commit <= 1'b1;
          wr_addr <= addr;
          wr_data <= {wr_shift[6:0], mdio_s};
        end
      end
    end
  end

  // Register file; the family identifier slot is read only
  genvar gi;
  generate
    for (gi = 0; gi < `CFG_REG_COUNT; gi = gi + 1) begin : g_reg
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          regs[gi] <= `CFG_REG_RESET;
        end else if (wr_commit && wr_addr == 8'(gi) && wr_addr != `CFG_ADDR_FAMILY) begin
          regs[gi] <= wr_data;
        end
      end
    end
  endgenerate

  assign o_power_down_ctrl = {regs[`CFG_PWR_HI], regs[`CFG_PWR_LO]};

  // Port windows, lowest address in the lowest byte
  genvar gp;
  generate
    for (gp = 0; gp < `CFG_PORT_REGS; gp = gp + 1) begin : g_port
      assign o_port1_ctrl[8*gp +: 8] = regs[`CFG_P1_LO + 8'(gp)];
      assign o_port2_ctrl[8*gp +: 8] = regs[`CFG_P2_LO + 8'(gp)];
    end
  endgenerate
  assign o_self_test_ctrl = regs[`CFG_SELF_TEST];

  // Checks
  read_decode_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    hdr_end && ext_sel && next_hdr[11:10] == `CFG_OP_READ |=> state == ST_TURN && is_read && !is_write)
    else $error("read frame not decoded");

  write_decode_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    hdr_end && ext_sel && next_hdr[11:10] == `CFG_OP_WRITE |=> state == ST_TURN && is_write && !is_read)
    else $error("write frame not decoded");

  addr_form_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    hdr_end |=> addr == {$past(next_hdr[9:8]), $past(next_hdr[5]), $past(next_hdr[4:0])})
    else $error("register address formed wrongly");

  ta_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_mdio_oe) |-> !o_mdio_out && is_read && state == ST_TURN && bit_cnt == 5'h01)
    else $error("turnaround drive wrong");

  upper_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state == ST_DATA && is_read && bit_cnt < 5'h08 |-> o_mdio_oe && !o_mdio_out)
    else $error("upper read byte not zero");

  release_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mdc_rise && state == ST_DATA && is_read && bit_cnt == 5'h0F |=> !o_mdio_oe ##1 !o_mdio_oe)
    else $error("line not released after read");

  no_write_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !is_read |-> !o_mdio_oe)
    else $error("line driven outside read");

  low_byte_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_commit && wr_addr == `CFG_SELF_TEST |=> o_self_test_ctrl == $past(wr_data) && wr_data == $past(wr_shift[7:0]))
    else $error("write low byte not stored");

  pwr_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_commit && wr_addr == `CFG_PWR_HI |=> o_power_down_ctrl[15:8] == $past(wr_data))
    else $error("power-down control not written");

  port_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_commit && wr_addr == `CFG_P2_LO |=> o_port2_ctrl[7:0] == $past(wr_data) && $stable(o_port1_ctrl))
    else $error("port control not written");

  preamble_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state == ST_PREAMBLE ##1 state == ST_START |-> $past(ones_cnt) == `CFG_PREAMBLE_ONES && !$past(mdio_s))
    else $error("start taken without preamble");

  range_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_commit && in_range(wr_addr, `CFG_P1_LO, `CFG_P1_HI) |=> o_port1_ctrl != 64'h0 || $past(wr_data) == 8'h00)
    else $error("port one write lost");

  hdr_len_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mdc_rise && state == ST_HEADER && bit_cnt == `CFG_HDR_BITS - 5'h01 |=> state != ST_HEADER)
    else $error("header length wrong");

  data_len_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mdc_rise && state == ST_DATA && bit_cnt == `CFG_DATA_BITS - 5'h01
    |=> state == ST_PREAMBLE && !is_read && !is_write)
    else $error("data field length wrong");

  idle_quiet_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    state == ST_PREAMBLE || state == ST_START || state == ST_HEADER |-> !o_mdio_oe)
    else $error("line driven outside data phase");

  first_bit_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mdc_rise && state == ST_TURN && is_read && bit_cnt == 5'h01 |=> o_mdio_oe && o_mdio_out == $past(rd_shift[15]))
    else $error("first read bit wrong");

  family_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    hdr_end && dec_read && form_addr(next_hdr[9:5], next_hdr[4:0]) == `CFG_ADDR_FAMILY
    |=> rd_shift == {`CFG_READ_PAD, FAMILY_IDENTIFIER})
    else $error("family identifier not loaded");

  wr_byte_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mdc_rise && state == ST_DATA && is_write && bit_cnt == `CFG_DATA_BITS - 5'h01
    |=> wr_commit && wr_data == wr_shift[7:0])
    else $error("write byte not captured");

endmodule
`default_nettype wire

// [inc/mdio_regs_cfg.svh]
`ifndef MDIO_REGS_CFG_SVH
`define MDIO_REGS_CFG_SVH

// Frame layout
`define CFG_PREAMBLE_ONES 6'h20
`define CFG_OP_READ 2'h2
`define CFG_OP_WRITE 2'h1
`define CFG_EXT_SEL 2'h3
`define CFG_HDR_BITS 5'h0C
`define CFG_DATA_BITS 5'h10
`define CFG_READ_PAD 8'h00

// Register space
`define CFG_REG_COUNT 256
`define CFG_REG_RESET 8'h00
`define CFG_ADDR_FAMILY 8'h00
`define CFG_PWR_LO 8'h0E
`define CFG_PWR_HI 8'h0F
`define CFG_P1_LO 8'h28
`define CFG_P1_HI 8'h2F
`define CFG_P2_LO 8'h38
`define CFG_P2_HI 8'h3F
`define CFG_PORT_REGS 8
`define CFG_SELF_TEST 8'h88

// Management clock limit
`define CFG_MDC_MAX_MHZ 10
`define CFG_REF_CLK_MHZ 100
`define CFG_MDC_MIN_CYCLES (`CFG_REF_CLK_MHZ / `CFG_MDC_MAX_MHZ)

`endif

// [inc/mdio_regs_pkg.sv]
package mdio_regs_pkg;
  typedef enum logic [2:0] {
    ST_PREAMBLE,
    ST_START,
    ST_HEADER,
    ST_TURN,
    ST_DATA
  } mgmt_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// [verilog/mdio_input_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module mdio_input_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Pin side
  input wire logic [WIDTH-1:0] i_async,
  // Synchronised side
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  // Two flops per bit; the first is read only by the second
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// [verification/mgmt_ctl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mgmt_ctl_model (
  // Management pins
  output logic o_mdc,
  output logic o_mdio_out,
  output logic o_mdio_oe,
  input wire logic i_mdio
);
  initial begin
    o_mdc = 1'b0;
    o_mdio_out = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // One bit, 125 ns clock, data set while clock low, sampled before rise
  task automatic bit_cycle(input logic drv, input logic val, output logic smp);
    o_mdio_oe = drv;
    o_mdio_out = val;
    #62;
    smp = i_mdio;
    o_mdc = 1'b1;
    #63;
    o_mdc = 1'b0;
  endtask
  // Whole frame; clock stands low afterwards
  task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] rad, input logic [15:0] wd, output logic [16:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, op, phy, rad};
    rd = '0;
    for (int i = 0; i < pre; i++) bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    if (op == 2'h2) begin
      bit_cycle(1'b0, 1'b0, s);
      for (int i = 16; i >= 0; i--) bit_cycle(1'b0, 1'b0, rd[i]);
    end else begin
      bit_cycle(1'b1, 1'b1, s);
      bit_cycle(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) bit_cycle(1'b1, wd[i], s);
    end
    o_mdio_oe = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [7:0] FAM = 8'h3C;  // Arbitrary value
  logic i_ref_clk, i_rst, mdc, ctl_out, ctl_oe, dev_out, dev_oe, mdio_w, oe_seen;
  logic [15:0] pwr;
  logic [63:0] p1, p2;
  logic [7:0] st;
  logic [16:0] rd;
  logic [7:0] adr [8] = '{8'h0E, 8'h0F, 8'h28, 8'h2F, 8'h38, 8'h3F, 8'h88, 8'hF5};
  logic [1:0] ops [5] = '{2'h1, 2'h0, 2'h3, 2'h1, 2'h2};
  logic [4:0] phys [5] = '{5'h07, 5'h07, 5'h07, 5'h03, 5'h05};
  int mismatches, total_checks, cycles;
  // Pulled-up shared data line
  assign mdio_w = dev_oe ? dev_out : (ctl_oe ? ctl_out : 1'b1);
  mgmt_ctl_model ctl_u (.o_mdc(mdc), .o_mdio_out(ctl_out), .o_mdio_oe(ctl_oe), .i_mdio(mdio_w));
  mdio_switch_register_access #(.FAMILY_IDENTIFIER(FAM)) dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio_out(dev_out), .o_mdio_oe(dev_oe),
    .o_power_down_ctrl(pwr), .o_port1_ctrl(p1), .o_port2_ctrl(p2), .o_self_test_ctrl(st));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (dev_oe === 1'b1) oe_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] hi);
    oe_seen = 1'b0;
    ctl_u.frame(32, 2'h1, {a[7:6], 2'b11, a[5]}, a[4:0], {hi, d}, rd);
    repeat (8) @(posedge i_ref_clk);
    check(64'(oe_seen), 64'h0, "drive in write");
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    ctl_u.frame(32, 2'h2, {a[7:6], 2'b11, a[5]}, a[4:0], 16'h0000, rd);
    check(64'(rd), {47'h0, 1'b0, 8'h00, exp}, "read data");
    repeat (3) @(posedge i_ref_clk);
    check(64'(dev_oe), 64'h0, "line kept after read");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    i_rst = 1'b1;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    oe_seen = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    check(64'({pwr, st}), 64'h0, "reset outputs");
    check(p1 | p2, 64'h0, "reset ports");
    check(64'({dev_oe, dev_out}), 64'h0, "reset line");
    rdchk(8'h00, FAM);
    wr(8'h00, 8'h11, 8'h00);
    rdchk(8'h00, FAM);
    // Decoded places and plain storage, upper byte set to ones
    for (int i = 0; i < 8; i++) begin
      wr(adr[i], adr[i] ^ 8'hA5, 8'hFF);
      rdchk(adr[i], adr[i] ^ 8'hA5);
    end
    check(64'(pwr), 64'hAAAB, "power-down decode");
    check(p1, {8'h8A, 48'h0, 8'h8D}, "port one decode");
    check(p2, {8'h9A, 48'h0, 8'h9D}, "port two decode");
    check(64'(st), 64'h2D, "self-test decode");
    // Short preamble first, while no idle ones precede it; then wrong opcode, wrong selector bits
    for (int k = 0; k < 5; k++) begin
      oe_seen = 1'b0;
      ctl_u.frame(k == 0 ? 31 : 32, ops[k], phys[k], 5'h08, 16'hFF00, rd);
      repeat (8) @(posedge i_ref_clk);
      check(64'(oe_seen), 64'h0, "ignored frame drove");
      check(p1, {8'h8A, 48'h0, 8'h8D}, "ignored frame wrote");
    end
    rdchk(8'h28, 8'h8D);
    @(posedge i_ref_clk);
    #1 i_rst = 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    check(64'({pwr, st}), 64'h0, "second reset");
    check(p1 | p2, 64'h0, "second reset ports");
    rdchk(8'hF5, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
